// ===== core/bmon_accum_power.sv
// Operation
// - offset cal enable shorts inputs; offset result stored for host.
// - enabled 32-bit accumulators add their selected source result every 500 ms.
// - current sign 0 adds to charge, sign 1 adds magnitude to discharge.
// - accumulation keeps conversion resolution, up to 15 bits plus sign.
// - no accumulation anywhere unless master accumulate enable is set.
// - charge time counter gains 2 counts per second while charging.
// - discharge time counter gains 2 counts per second while discharging.
// - temperature accumulator needs enable; select picks internal or external.
// - cell accumulator adds second cell result only when its enable is set.
// - each timer gains 2 counts per second while its accumulator accumulates.
// - Run repeats conversion cycles of 1 to 8 conversions, then updates.
// - after reset, Run once pack above power-on threshold; back to POR if it drops.
// - sample bit selects periodic Sample mode; clearing returns to Run.
// - sample interval is two to the divider times half a second.
// - Sample-Sleep: analog off, sleep oscillator timing, wakes per interval.
// - Sample-Sleep entered on cell trip, host sleep bit or low current trip.
// - no Sample-Sleep entry while charge wake enabled and current high.
// - sleep interval is two to sample divider times two to sleep divider.
// - leave Sample-Sleep on sleep bit clear, charge wake or pack wake.
// - Shelf-Sleep: no measuring or accumulating, bus ignored, state lost.
// - shelf armed by enable or low pack; entered after lines low long enough.
// - shelf exits to Run after both lines high for minimum wake time.
//
// Local design decisions: register access over AHB-Lite and the register offsets.
module bmon_accum_power
    import bmon_pkg::*;
#(
    parameter int unsigned HALF_SEC_CYCLES   = HALF_SEC_CYC,
    parameter int unsigned SLP_TICKS_HALF    = 16,
    parameter int unsigned SHELF_ENTRY_TICKS = 64,
    parameter int unsigned SHELF_WAKE_TICKS  = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire bmon_conv_t  conv,
    input  wire logic        seq_busy,
    input  wire bmon_cmp_t   cmp,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        slp_osc,
    output bmon_ctrl_t       ctrl,
    output bmon_mode_t       mode
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---- pin synchronisers
    localparam int SW = 10;
    logic [SW-1:0] raw;
    logic [SW-1:0] s1_r;
    logic [SW-1:0] s2_r;
    logic [SW-1:0] s3_r;
    logic [SW-1:0] flt_r;
    logic [SW-1:0] flt_nxt;
    bmon_cmp_t     cs;
    logic          scl_f;
    logic          sda_f;
    logic          slp_tick;

    assign raw = {slp_osc, sda_in, scl_in, cmp};

    // a bit moves only once stages two and three agree
    always_comb begin
        flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            flt_r <= '0;
        end else begin
            s1_r  <= raw;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            flt_r <= flt_nxt;
        end
    end

    assign cs       = bmon_cmp_t'(flt_r[6:0]);
    assign scl_f    = flt_r[7];
    assign sda_f    = flt_r[8];
    assign slp_tick = flt_nxt[9] & ~flt_r[9];

    // ---- state
    bmon_mode_t  mode_r, mode_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic        wr_pend_r, wr_pend_nxt;
    logic [7:0]  wr_addr_r, wr_addr_nxt;
    logic [3:0]  acc_ctl_r, acc_ctl_nxt;
    logic [6:0]  adc_r, adc_nxt;
    logic [4:0]  op_r, op_nxt;
    logic [4:0]  trip_r, trip_nxt;
    logic        offs_ctl_r, offs_ctl_nxt;
    logic [15:0] offs_res_r, offs_res_nxt;
    logic [15:0] res_r   [8];
    logic [15:0] res_nxt [8];
    logic [31:0] acc_r   [8];
    logic [31:0] acc_nxt [8];
    logic [31:0] inc     [8];
    logic [7:0]  add_en;
    logic [31:0] half_cnt_r, half_cnt_nxt;
    logic [7:0]  samp_cnt_r, samp_cnt_nxt;
    logic [31:0] slp_cnt_r, slp_cnt_nxt;
    logic [15:0] shelf_cnt_r, shelf_cnt_nxt;
    logic [15:0] wake_cnt_r, wake_cnt_nxt;
    logic        awake_r, awake_nxt;
    logic        busy_d_r;
    bmon_ctrl_t  ctrl_r, ctrl_nxt;

    logic        ap;
    logic        in_shelf;
    logic        we;
    logic        half_tick;
    logic        acc_go;
    logic [15:0] cur;
    logic [31:0] mag;
    logic [31:0] rd_val;
    logic [7:0]  samp_lim;
    logic [3:0]  shamt;
    logic [31:0] slp_lim;
    logic        slp_fire;
    logic        sleep_in;
    logic        wake_ev;
    logic        shelf_arm;
    logic        lines_low;
    logic        lines_high;
    logic        shelf_go;
    logic        wake_go;
    logic        start;

    assign ap = hsel & hready & htrans[1] & (haddr[31:8] == 24'h0);
    assign in_shelf  = (mode_r == MODE_SHELF);
    assign we        = wr_pend_r & ~in_shelf;
    assign half_tick = (half_cnt_r == 32'(HALF_SEC_CYCLES - 1));
    assign acc_go    = half_tick & acc_ctl_r[ACC_EN_B]
                     & (mode_r inside {MODE_RUN, MODE_SAMPLE, MODE_SSLEEP});
    assign cur = res_r[CH_CURR];
    assign mag = {17'h0, cur[14:0]};

    // ---- bus and software registers
    always_comb begin
        wr_pend_nxt  = ap & hwrite;
        wr_addr_nxt  = ap ? haddr[7:0] : wr_addr_r;
        acc_ctl_nxt  = acc_ctl_r;
        adc_nxt      = adc_r;
        op_nxt       = op_r;
        trip_nxt     = trip_r;
        offs_ctl_nxt = offs_ctl_r;
        offs_res_nxt = offs_res_r;
        if (we && wr_addr_r == A_ACC_CTL) begin
            acc_ctl_nxt = hwdata[3:0];
        end else if (we && wr_addr_r == A_ADC_CFG) begin
            adc_nxt = hwdata[6:0];
        end else if (we && wr_addr_r == A_OPERATING_MODE_CONTROL) begin
            op_nxt = hwdata[4:0];
        end else if (we && wr_addr_r == A_TRIP) begin
            trip_nxt = hwdata[4:0];
        end else if (we && wr_addr_r == A_OFFSET_CTL) begin
            offs_ctl_nxt = hwdata[0];
        end
        if (conv.valid && conv.chan == CH_OFFS && offs_ctl_r) begin
            offs_res_nxt = conv.data;
        end
        if (in_shelf) begin
            acc_ctl_nxt  = RST_ACC_CTL;
            adc_nxt      = RST_ADC_CFG;
            op_nxt       = RST_OPERATING_MODE_CONTROL;
            trip_nxt     = RST_TRIP;
            offs_ctl_nxt = 1'b0;
            offs_res_nxt = RST_RESULT;
        end
    end

    // reads see next values, so a write just before is never stale
    always_comb begin
        rd_val = 32'h0;
        if (haddr[7:0] == A_ACC_CTL) begin
            rd_val = {28'h0, acc_ctl_nxt};
        end else if (haddr[7:0] == A_ADC_CFG) begin
            rd_val = {25'h0, adc_nxt};
        end else if (haddr[7:0] == A_OPERATING_MODE_CONTROL) begin
            rd_val = {21'h0, mode_r, 3'h0, op_nxt};
        end else if (haddr[7:0] == A_TRIP) begin
            rd_val = {27'h0, trip_nxt};
        end else if (haddr[7:0] == A_OFFSET_CTL) begin
            rd_val = {31'h0, offs_ctl_nxt};
        end else if (haddr[7:0] == A_OFFSET_RES) begin
            rd_val = {16'h0, offs_res_nxt};
        end else if (haddr[7:5] == A_ACC_BASE[7:5]) begin
            rd_val = acc_nxt[haddr[4:2]];
        end
        hrdata_nxt = (ap && !hwrite) ? rd_val : hrdata_r;
    end

    // ---- results and accumulators
    always_comb begin
        add_en = '0;
        for (int i = 0; i < 8; i++) begin
            res_nxt[i] = res_r[i];
            inc[i]     = TIME_INC;
        end
        if (conv.valid) begin
            res_nxt[conv.chan] = conv.data;
        end
        inc[IX_CHG]  = mag;
        inc[IX_DCHG] = mag;
        inc[IX_TEMP] = bmon_sm_to_s32(acc_ctl_r[TSEL_B] ? res_r[CH_ETEMP]
                                                        : res_r[CH_ITEMP]);
        inc[IX_CELL] = bmon_sm_to_s32(res_r[CH_CELL2]);
        add_en[IX_CHG]   = acc_go & ~cur[15];
        add_en[IX_DCHG]  = acc_go & cur[15];
        add_en[IX_CTIME] = acc_go & ~cur[15];
        add_en[IX_DTIME] = acc_go & cur[15];
        add_en[IX_TEMP]  = acc_go & acc_ctl_r[TEMP_EN_B];
        add_en[IX_CELL]  = acc_go & acc_ctl_r[CELL_EN_B];
        add_en[IX_TTIM]  = add_en[IX_TEMP];
        add_en[IX_CTIM]  = add_en[IX_CELL];
        for (int i = 0; i < 8; i++) begin
            acc_nxt[i] = add_en[i] ? acc_r[i] + inc[i] : acc_r[i];
            if (we && wr_addr_r[7:5] == A_ACC_BASE[7:5]
                    && wr_addr_r[4:2] == 3'(i)) begin
                acc_nxt[i] = hwdata;
            end
            if (in_shelf) begin
                acc_nxt[i] = RST_ACC;
                res_nxt[i] = RST_RESULT;
            end
        end
    end

    // ---- timing and mode control
    assign samp_lim   = (8'h01 << adc_r[SDIV_LSB +: 3]) - 8'h01;
    assign shamt      = {1'b0, adc_r[SDIV_LSB +: 3]}
                      + {1'b0, op_r[SLDIV_LSB +: 3]};
    assign slp_lim    = (32'(SLP_TICKS_HALF) << shamt) - 32'h1;
    assign slp_fire   = (mode_r == MODE_SSLEEP) & slp_tick
                      & (slp_cnt_r == slp_lim);
    assign sleep_in   = (cs.cell1_low & trip_r[C1_ENT_B])
                      | (cs.cell2_low & trip_r[C2_ENT_B])
                      | op_r[SLEEP_REQ_B]
                      | (cs.current_low & trip_r[ILO_ENT_B]);
    assign wake_ev    = (trip_r[IWAKE_B] & cs.charge_above_wake)
                      | (trip_r[VWAKE_B] & cs.pack_above_wake);
    assign shelf_arm  = op_r[SHELF_B] | cs.pack_below_shelf;
    assign lines_low  = ~scl_f & ~sda_f;
    assign lines_high = scl_f & sda_f;
    // lines must still be low when the count completes
    assign shelf_go   = shelf_arm & lines_low
                      & (shelf_cnt_r == 16'(SHELF_ENTRY_TICKS));
    assign wake_go    = (wake_cnt_r == 16'(SHELF_WAKE_TICKS));

    always_comb begin
        half_cnt_nxt  = half_tick ? 32'h0 : half_cnt_r + 32'h1;
        samp_cnt_nxt  = 8'h00;
        slp_cnt_nxt   = 32'h0;
        shelf_cnt_nxt = 16'h0;
        wake_cnt_nxt  = 16'h0;
        start         = 1'b0;
        mode_nxt      = mode_r;
        if (shelf_arm && lines_low && !in_shelf && !shelf_go) begin
            shelf_cnt_nxt = shelf_cnt_r + 16'(slp_tick);
        end else if (shelf_arm && lines_low && !in_shelf) begin
            shelf_cnt_nxt = shelf_cnt_r;
        end
        case (mode_r)
            MODE_POR: begin
                if (cs.pack_above_por) begin
                    mode_nxt = MODE_RUN;
                end
            end
            MODE_SHELF: begin
                if (lines_high && !wake_go) begin
                    wake_cnt_nxt = wake_cnt_r + 16'(slp_tick);
                end else if (lines_high) begin
                    mode_nxt = MODE_RUN;
                end
            end
            default: begin
                if (mode_r == MODE_RUN) begin
                    start = ~seq_busy & ~ctrl_r.conv_start;
                end else if (mode_r == MODE_SAMPLE) begin
                    start = half_tick & (samp_cnt_r == samp_lim);
                    samp_cnt_nxt = samp_cnt_r;
                    if (half_tick) begin
                        samp_cnt_nxt = start ? 8'h00 : samp_cnt_r + 8'h01;
                    end
                end else begin
                    start = slp_fire;
                    slp_cnt_nxt = slp_cnt_r;
                    if (slp_tick) begin
                        slp_cnt_nxt = slp_fire ? 32'h0 : slp_cnt_r + 32'h1;
                    end
                end
                if (!cs.pack_above_por) begin
                    mode_nxt = MODE_POR;
                end else if (shelf_go) begin
                    mode_nxt = MODE_SHELF;
                end else if (sleep_in && !wake_ev) begin
                    mode_nxt = MODE_SSLEEP;
                end else if (adc_r[SAMPLE_B]) begin
                    mode_nxt = MODE_SAMPLE;
                end else begin
                    mode_nxt = MODE_RUN;
                end
            end
        endcase
        // analog stays up from a sleep wake until the sequence ends
        awake_nxt = (mode_r == MODE_SSLEEP)
                  & (slp_fire | (awake_r & ~(busy_d_r & ~seq_busy)));
        ctrl_nxt.conv_start   = start;
        ctrl_nxt.conv_count   = adc_r[NCONV_LSB +: 3];
        ctrl_nxt.offset_short = offs_ctl_r;
        ctrl_nxt.analog_on    = (mode_r inside {MODE_RUN, MODE_SAMPLE})
                              | awake_r;
        ctrl_nxt.bus_ignore   = in_shelf;
        ctrl_nxt.sleep_active = (mode_r == MODE_SSLEEP) & ~awake_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r      <= MODE_POR;
            hrdata_r    <= 32'h0;
            wr_pend_r   <= 1'b0;
            wr_addr_r   <= 8'h00;
            acc_ctl_r   <= RST_ACC_CTL;
            adc_r       <= RST_ADC_CFG;
            op_r        <= RST_OPERATING_MODE_CONTROL;
            trip_r      <= RST_TRIP;
            offs_ctl_r  <= 1'b0;
            offs_res_r  <= RST_RESULT;
            half_cnt_r  <= 32'h0;
            samp_cnt_r  <= 8'h00;
            slp_cnt_r   <= 32'h0;
            shelf_cnt_r <= 16'h0;
            wake_cnt_r  <= 16'h0;
            awake_r     <= 1'b0;
            busy_d_r    <= 1'b0;
            ctrl_r      <= '0;
            for (int i = 0; i < 8; i++) begin
                res_r[i] <= RST_RESULT;
                acc_r[i] <= RST_ACC;
            end
        end else begin
            mode_r      <= mode_nxt;
            hrdata_r    <= hrdata_nxt;
            wr_pend_r   <= wr_pend_nxt;
            wr_addr_r   <= wr_addr_nxt;
            acc_ctl_r   <= acc_ctl_nxt;
            adc_r       <= adc_nxt;
            op_r        <= op_nxt;
            trip_r      <= trip_nxt;
            offs_ctl_r  <= offs_ctl_nxt;
            offs_res_r  <= offs_res_nxt;
            half_cnt_r  <= half_cnt_nxt;
            samp_cnt_r  <= samp_cnt_nxt;
            slp_cnt_r   <= slp_cnt_nxt;
            shelf_cnt_r <= shelf_cnt_nxt;
            wake_cnt_r  <= wake_cnt_nxt;
            awake_r     <= awake_nxt;
            busy_d_r    <= seq_busy;
            ctrl_r      <= ctrl_nxt;
            for (int i = 0; i < 8; i++) begin
                res_r[i] <= res_nxt[i];
                acc_r[i] <= acc_nxt[i];
            end
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign ctrl      = ctrl_r;
    assign mode      = mode_r;

    // ---- checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_offset_capture: assert property (
        conv.valid && conv.chan == CH_OFFS && offs_ctl_r && !in_shelf
        |=> offs_res_r == $past(conv.data))
        else $error("offset result not captured");
    a_discharge_idle: assert property (
        acc_go && !cur[15] && !wr_pend_r
        |=> acc_r[IX_DCHG] == $past(acc_r[IX_DCHG]))
        else $error("discharge moved on charge sample");
    a_master_gate: assert property (
        !acc_ctl_r[ACC_EN_B] && !wr_pend_r && !in_shelf
        |=> $stable(acc_r[IX_CHG]) && $stable(acc_r[IX_TEMP]))
        else $error("accumulated while disabled");
    a_charge_time: assert property (
        acc_go && !cur[15] && !wr_pend_r
        |=> acc_r[IX_CTIME] == $past(acc_r[IX_CTIME]) + TIME_INC)
        else $error("charge time count wrong");
    a_discharge_time: assert property (
        acc_go && cur[15] && !wr_pend_r
        |=> acc_r[IX_DTIME] == $past(acc_r[IX_DTIME]) + TIME_INC)
        else $error("discharge time count wrong");
    a_temp_gate: assert property (
        half_tick && !acc_ctl_r[TEMP_EN_B] && !wr_pend_r && !in_shelf
        |=> $stable(acc_r[IX_TEMP]) && $stable(acc_r[IX_TTIM]))
        else $error("temperature path moved while off");
    a_run_restart: assert property (
        mode_r == MODE_RUN && !seq_busy && !ctrl_r.conv_start
        |=> ctrl_r.conv_start)
        else $error("run mode did not restart");
    a_power_drop: assert property (
        !cs.pack_above_por && mode_r != MODE_SHELF
        |=> mode_r == MODE_POR)
        else $error("no fallback on low pack");
    a_sleep_block: assert property (
        mode_r != MODE_SSLEEP && trip_r[IWAKE_B] && cs.charge_above_wake
        |=> mode_r != MODE_SSLEEP)
        else $error("slept during charge wake");
    a_shelf_entry: assert property (
        mode_r == MODE_SHELF && $past(mode_r) != MODE_SHELF
        |-> $past(shelf_cnt_r) == 16'(SHELF_ENTRY_TICKS) && $past(lines_low))
        else $error("shelf entered early");
    a_shelf_wake: assert property (
        mode_r == MODE_RUN && $past(mode_r) == MODE_SHELF
        |-> $past(wake_cnt_r) == 16'(SHELF_WAKE_TICKS) && $past(lines_high))
        else $error("shelf left early");
    a_shelf_silent: assert property (
        in_shelf ##1 in_shelf |-> ctrl_r.bus_ignore && !ctrl_r.analog_on
        && acc_r[IX_CHG] == RST_ACC)
        else $error("shelf not silent");

    c_sleep_entry:  cover property (mode_r == MODE_SAMPLE ##1
                                    mode_r == MODE_SSLEEP);
    c_sleep_wake:   cover property (slp_fire ##1 awake_r);
    c_discharge:    cover property (acc_go && cur[15]);
    c_shelf_return: cover property (in_shelf ##1 mode_r == MODE_RUN);

endmodule // bmon_accum_power

// ===== core/bmon_pkg.sv
package bmon_pkg;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned HALF_SEC_MS   = 500;
    localparam int unsigned HALF_SEC_CYC  =
        HALF_SEC_MS * 1_000_000 / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] A_ACC_CTL    = 8'h00;
    localparam logic [7:0] A_ADC_CFG    = 8'h04;
    localparam logic [7:0] A_OPERATING_MODE_CONTROL     = 8'h08;
    localparam logic [7:0] A_TRIP       = 8'h0c;
    localparam logic [7:0] A_OFFSET_CTL = 8'h10;
    localparam logic [7:0] A_OFFSET_RES = 8'h14;
    localparam logic [7:0] A_ACC_BASE   = 8'h20;

    // field positions
    localparam int ACC_EN_B    = 0;
    localparam int TEMP_EN_B   = 1;
    localparam int TSEL_B      = 2;
    localparam int CELL_EN_B   = 3;
    localparam int SAMPLE_B    = 0;
    localparam int SDIV_LSB    = 1;
    localparam int NCONV_LSB   = 4;
    localparam int SLEEP_REQ_B = 0;
    localparam int SLDIV_LSB   = 1;
    localparam int SHELF_B     = 4;
    localparam int MODE_LSB    = 8;
    localparam int C1_ENT_B    = 0;
    localparam int C2_ENT_B    = 1;
    localparam int ILO_ENT_B   = 2;
    localparam int IWAKE_B     = 3;
    localparam int VWAKE_B     = 4;

    // reset values
    localparam logic [3:0]  RST_ACC_CTL = 4'h0;
    localparam logic [6:0]  RST_ADC_CFG = 7'h00;
    localparam logic [4:0]  RST_OPERATING_MODE_CONTROL  = 5'h00;
    localparam logic [4:0]  RST_TRIP    = 5'h00;
    localparam logic [15:0] RST_RESULT  = 16'h0000;
    localparam logic [31:0] RST_ACC     = 32'h0000_0000;

    // converter channels and accumulator slots
    localparam logic [2:0] CH_CURR  = 3'h0;
    localparam logic [2:0] CH_ITEMP = 3'h1;
    localparam logic [2:0] CH_ETEMP = 3'h2;
    localparam logic [2:0] CH_CELL2 = 3'h5;
    localparam logic [2:0] CH_OFFS  = 3'h6;
    localparam int IX_CHG   = 0;
    localparam int IX_DCHG  = 1;
    localparam int IX_CTIME = 2;
    localparam int IX_DTIME = 3;
    localparam int IX_TEMP  = 4;
    localparam int IX_CELL  = 5;
    localparam int IX_TTIM  = 6;
    localparam int IX_CTIM  = 7;
    // 2 counts per second is one count per half-second update
    localparam logic [31:0] TIME_INC = 32'h0000_0001;

    typedef enum logic [2:0] {
        MODE_POR, MODE_RUN, MODE_SAMPLE, MODE_SSLEEP, MODE_SHELF
    } bmon_mode_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  chan;
        logic [15:0] data;
    } bmon_conv_t;

    typedef struct packed {
        logic charge_above_wake;
        logic current_low;
        logic cell2_low;
        logic cell1_low;
        logic pack_above_wake;
        logic pack_below_shelf;
        logic pack_above_por;
    } bmon_cmp_t;

    typedef struct packed {
        logic       conv_start;
        logic [2:0] conv_count;
        logic       offset_short;
        logic       analog_on;
        logic       bus_ignore;
        logic       sleep_active;
    } bmon_ctrl_t;

    function automatic logic [31:0] bmon_sm_to_s32(input logic [15:0] v);
        bmon_sm_to_s32 = v[15] ? (32'h0 - {17'h0, v[14:0]})
                               : {17'h0, v[14:0]};
    endfunction

endpackage

// ===== tb/bmon_far_model.sv
module bmon_far_model
    import bmon_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire bmon_ctrl_t       ctrl,
    input  wire logic [4:0][15:0] res_d,
    output bmon_conv_t            conv,
    output logic                  seq_busy,
    output logic                  slp_osc
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0][2:0] CHT =
        {CH_OFFS, CH_CELL2, CH_ETEMP, CH_ITEMP, CH_CURR};
    logic [2:0] k;
    logic [2:0] div;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            k        <= 3'h0;
            conv     <= '0;
            seq_busy <= 1'b0;
            slp_osc  <= 1'b0;
            div      <= 3'h0;
        end else begin
            // sleep clock at hclk/8, slower than the sync needs
            div        <= div + 3'h1;
            slp_osc    <= div[2];
            conv.valid <= 1'b0;
            conv.data  <= ~conv.data;
            if (ctrl.conv_start) begin
                seq_busy <= 1'b1;
                k        <= 3'h1;
            end else if (k != 3'h0) begin
                k          <= (k == 3'h5) ? 3'h0 : k + 3'h1;
                conv.valid <= 1'b1;
                conv.chan  <= CHT[k - 3'h1];
                conv.data  <= res_d[k - 3'h1];
                if (k == 3'h5)
                    seq_busy <= 1'b0;
            end
        end
    end
endmodule // bmon_far_model

// ===== tb/tb.sv
module tb
    import bmon_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, scl_in, sda_in;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [4:0][15:0] res_d;
    bmon_conv_t conv;
    logic seq_busy, slp_osc;
    bmon_cmp_t cmp;
    bmon_ctrl_t ctrl;
    bmon_mode_t mode;
    logic [31:0] v [8];
    int bad_count, comparisons;
    bmon_accum_power #(.HALF_SEC_CYCLES(50), .SLP_TICKS_HALF(2),
        .SHELF_ENTRY_TICKS(4), .SHELF_WAKE_TICKS(2)) dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv(conv),
        .seq_busy(seq_busy), .cmp(cmp), .scl_in(scl_in), .sda_in(sda_in),
        .slp_osc(slp_osc), .ctrl(ctrl), .mode(mode));
    bmon_far_model far (.hclk(hclk), .hresetn(hresetn), .ctrl(ctrl),
        .res_d(res_d), .conv(conv), .seq_busy(seq_busy), .slp_osc(slp_osc));
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task stop_test;
        if (bad_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task wmode(input bmon_mode_t m);
        int n;
        n = 0;
        while (mode !== m && n < 500) begin
            @(posedge hclk);
            n++;
        end
        chk("mode", mode, m);
    endtask
    // accumulate with a fresh start, then freeze and read all eight
    task run(input logic [3:0] c);
        int i;
        xfer(A_ACC_CTL, 1'b1, 32'h0);
        for (i = 0; i < 8; i++) xfer(A_ACC_BASE + 8'(4 * i), 1'b1, 32'h0);
        xfer(A_ACC_CTL, 1'b1, {28'h0, c});
        repeat (300) @(posedge hclk);
        xfer(A_ACC_CTL, 1'b1, 32'h0);
        for (i = 0; i < 8; i++) begin
            xfer(A_ACC_BASE + 8'(4 * i), 1'b0, 32'h0);
            v[i] = r;
        end
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    initial begin
        #100us;
        bad_count++;
        stop_test;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = '0;
        hwrite = 1'b0;
        hwdata = '0;
        cmp = '0;
        scl_in = 1'b1;
        sda_in = 1'b1;
        res_d = {16'h0009, 16'h8001, 16'h8002, 16'h0007, 16'h0005};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        chk("por", mode, MODE_POR);
        cmp.pack_above_por <= 1'b1;
        wmode(MODE_RUN);
        run(4'h3);
        chk("ct", v[IX_CTIME] != 0, 1);
        chk("chg", v[IX_CHG], 32'h5 * v[IX_CTIME]);
        chk("dt", v[IX_DTIME] | v[IX_DCHG], 0);
        chk("tmp", v[IX_TEMP], 32'h7 * v[IX_TTIM]);
        chk("tt", v[IX_TTIM], v[IX_CTIME]);
        chk("cel", v[IX_CELL] | v[IX_CTIM], 0);
        run(4'he);
        chk("off", v[IX_CHG] | v[IX_TEMP] | v[IX_CELL], 0);
        res_d[0] <= 16'h8003;
        run(4'hf);
        chk("dt", v[IX_DTIME] != 0, 1);
        chk("dchg", v[IX_DCHG], 32'h3 * v[IX_DTIME]);
        chk("ct", v[IX_CTIME] | v[IX_CHG], 0);
        chk("ext", v[IX_TEMP] + 32'h2 * v[IX_TTIM], 0);
        chk("cel", v[IX_CELL] + v[IX_CTIM], 0);
        chk("ctm", v[IX_CTIM], v[IX_DTIME]);
        xfer(A_OFFSET_RES, 1'b0, 0);
        chk("ofs0", r, 0);
        xfer(A_OFFSET_CTL, 1'b1, 32'h1);
        repeat (50) @(posedge hclk);
        xfer(A_OFFSET_RES, 1'b0, 0);
        chk("ofs", r, 32'h9);
        chk("short", ctrl.offset_short, 32'h1);
        xfer(A_ADC_CFG, 1'b1, 32'h31);
        wmode(MODE_SAMPLE);
        chk("cnt", ctrl.conv_count, 32'h3);
        xfer(A_ADC_CFG, 1'b1, 32'h0);
        wmode(MODE_RUN);
        cmp.charge_above_wake <= 1'b1;
        xfer(A_TRIP, 1'b1, 32'h8);
        xfer(A_OPERATING_MODE_CONTROL, 1'b1, 32'h1);
        repeat (50) @(posedge hclk);
        chk("nowake", mode, MODE_RUN);
        cmp.charge_above_wake <= 1'b0;
        wmode(MODE_SSLEEP);
        repeat (2) @(posedge hclk);
        chk("slp", {ctrl.analog_on, ctrl.sleep_active}, 32'h1);
        xfer(A_OPERATING_MODE_CONTROL, 1'b1, 32'h0);
        wmode(MODE_RUN);
        xfer(A_OPERATING_MODE_CONTROL, 1'b1, 32'h10);
        scl_in <= 1'b0;
        sda_in <= 1'b0;
        wmode(MODE_SHELF);
        xfer(A_ACC_CTL, 1'b1, 32'h1);
        xfer(A_ACC_CTL, 1'b0, 0);
        chk("shelf", r, 0);
        scl_in <= 1'b1;
        sda_in <= 1'b1;
        wmode(MODE_RUN);
        stop_test;
    end
endmodule // tb
